// ---- rtsf_top.sv ----
/*
  relay special functions: on-delay, off-delay with reset, pulse relay
  and weekly time switch with three cams, behind an APB slave.
  assumes block inputs arrive asynchronously on pins and that the
  time-of-day part sits on a backup-powered supply that presetn leaves alone
  except at first power-up.
*/
`timescale 1ns/10ps
`include "rtsf_consts.svh"

module rtsf_top
  import rtsf_pkg::*;
#(
  parameter int unsigned TICK_CYC = `RTSF_TICK_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire rtsf_in_t    sf_in,
  output rtsf_out_t        sf_out
);

  // input synchronisers and edge detection
  logic [7:0] sync1_q, sync2_q, sync3_q, stable_q, prev_q;
  logic [7:0] sync1_d, sync2_d, sync3_d, stable_d, prev_d;
  rtsf_in_t   lvl, rise, fall;

  always_comb begin
    sync1_d  = sf_in;
    sync2_d  = sync1_q;
    sync3_d  = sync2_q;
    // a change counts only once two later stages agree
    stable_d = (sync2_q == sync3_q) ? sync3_q : stable_q;
    prev_d   = stable_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q  <= 8'h00;
      sync2_q  <= 8'h00;
      sync3_q  <= 8'h00;
      stable_q <= 8'h00;
      prev_q   <= 8'h00;
    end else begin
      sync1_q  <= sync1_d;
      sync2_q  <= sync2_d;
      sync3_q  <= sync3_d;
      stable_q <= stable_d;
      prev_q   <= prev_d;
    end
  end

  assign lvl  = stable_q;
  assign rise = stable_q & ~prev_q;
  assign fall = ~stable_q & prev_q;

  // time base: one 10 ms tick shared by every delay
  logic [17:0] pre_q, pre_d;
  logic        tick_q, tick_d;

  always_comb begin
    tick_d = 1'b0;
    pre_d  = pre_q + 18'h00001;
    if (pre_q == 18'(TICK_CYC - 1)) begin
      pre_d  = 18'h00000;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q  <= 18'h00000;
      tick_q <= 1'b0;
    end else begin
      pre_q  <= pre_d;
      tick_q <= tick_d;
    end
  end

  // APB registers
  logic [15:0] on_dly_q, on_dly_d, off_dly_q, off_dly_d;
  rtsf_cam_t   cam_q [3];
  rtsf_cam_t   cam_d [3];
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d, pslverr_q, pslverr_d;
  logic        tset_d;
  logic [10:0] tset_min;
  logic [2:0]  tset_day;
  logic [15:0] on_el_q, off_el_q;
  logic [10:0] min_q;
  logic [2:0]  day_q;
  rtsf_out_t   out_q;

  wire acc = psel && penable && !pready_q;

  always_comb begin
    on_dly_d  = on_dly_q;
    off_dly_d = off_dly_q;
    for (int i = 0; i < 3; i++) begin
      cam_d[i] = cam_q[i];
    end
    prdata_d  = 32'h00000000;
    pready_d  = acc;
    pslverr_d = 1'b0;
    tset_d    = 1'b0;
    tset_min  = pwdata[10:0];
    tset_day  = pwdata[`RTSF_TIME_DAY_LSB +: 3];
    if (acc) begin
      case (paddr)
        `RTSF_OFS_ON_DELAY: begin
          prdata_d = {16'h0000, on_dly_q};
          if (pwrite) on_dly_d = pwdata[15:0];
        end
        `RTSF_OFS_OFF_DELAY: begin
          prdata_d = {16'h0000, off_dly_q};
          if (pwrite) off_dly_d = pwdata[15:0];
        end
        `RTSF_OFS_CAM1, `RTSF_OFS_CAM2, `RTSF_OFS_CAM3: begin
          for (int i = 0; i < 3; i++) begin
            if (paddr == 12'(`RTSF_OFS_CAM1 + 4 * i)) begin
              prdata_d = {6'h00, cam_q[i]};
              if (pwrite) cam_d[i] = rtsf_cam_t'(pwdata[25:0]);
            end
          end
        end
        `RTSF_OFS_TIME: begin
          prdata_d = {13'h0000, day_q, 5'h00, min_q};
          // out-of-range values are refused, the clock keeps its time
          if (pwrite && tset_min < `RTSF_MIN_PER_DAY && tset_day != 3'h7)
            tset_d = 1'b1;
        end
        `RTSF_OFS_STATUS:      prdata_d = {28'h0000000, out_q};
        `RTSF_OFS_ON_ELAPSED:  prdata_d = {16'h0000, on_el_q};
        `RTSF_OFS_OFF_ELAPSED: prdata_d = {16'h0000, off_el_q};
        default:               pslverr_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_dly_q  <= `RTSF_DELAY_RST;
      off_dly_q <= `RTSF_DELAY_RST;
      for (int i = 0; i < 3; i++) begin
        cam_q[i] <= rtsf_cam_t'(`RTSF_CAM_RST);
      end
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      on_dly_q  <= on_dly_d;
      off_dly_q <= off_dly_d;
      for (int i = 0; i < 3; i++) begin
        cam_q[i] <= cam_d[i];
      end
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // delay timers and pulse relay
  logic [15:0] on_el_d, off_el_d;
  logic        off_run_q, off_run_d;
  logic        tsw_next;
  rtsf_out_t   out_d;
  wire         restore = rise.pwr_ok;

  always_comb begin
    on_el_d   = on_el_q;
    off_el_d  = off_el_q;
    off_run_d = off_run_q;
    out_d     = out_q;

    // on-delay
    if (lvl.on_rst || !lvl.on_trg || rise.on_trg) begin
      on_el_d    = 16'h0000;
      out_d.on_q = 1'b0;
    end else if (on_el_q >= on_dly_q) begin
      out_d.on_q = 1'b1;
    end else if (tick_q) begin
      on_el_d = on_el_q + 16'h0001;
    end

    // off-delay
    if (lvl.off_rst) begin
      off_el_d    = 16'h0000;
      off_run_d   = 1'b0;
      out_d.off_q = 1'b0;
    end else if (lvl.off_trg) begin
      out_d.off_q = 1'b1;
      off_run_d   = 1'b0;
      off_el_d    = 16'h0000;
    end else if (fall.off_trg) begin
      off_el_d  = 16'h0000;
      off_run_d = 1'b1;
    end else if (off_run_q) begin
      if (off_el_q == off_dly_q) begin
        out_d.off_q = 1'b0;
        off_run_d   = 1'b0;
      end else if (tick_q) begin
        off_el_d = off_el_q + 16'h0001;
      end
    end

    // pulse relay
    if (lvl.pls_rst) out_d.pls_q = 1'b0;
    else if (rise.pls_trg) out_d.pls_q = ~out_q.pls_q;

    // mains returned: elapsed times start over, outputs follow
    if (restore) begin
      on_el_d     = 16'h0000;
      off_el_d    = 16'h0000;
      off_run_d   = 1'b0;
      out_d.on_q  = 1'b0;
      out_d.off_q = lvl.off_trg && !lvl.off_rst;
      out_d.pls_q = 1'b0;
    end
    out_d.tsw_q = tsw_next;
  end

  // weekly time switch
  logic [12:0] sub_q, sub_d;
  logic [10:0] min_d;
  logic [2:0]  day_d;
  logic        eval_q, eval_d;

  function automatic logic day_hit(input rtsf_day_sel_t sel, input logic [2:0] d);
    logic hit;
    hit = 1'b0;
    case (sel)
      RTSF_MO_FR: hit = (d >= 3'h1) && (d <= 3'h5);
      RTSF_MO_SA: hit = (d >= 3'h1) && (d <= 3'h6);
      RTSF_MO_SU: hit = 1'b1;
      RTSF_SA_SU: hit = (d == 3'h0) || (d == 3'h6);
      default:    hit = (sel <= RTSF_SA) && (sel[2:0] == d);
    endcase
    return hit;
  endfunction

  always_comb begin
    sub_d  = sub_q;
    min_d  = min_q;
    day_d  = day_q;
    eval_d = 1'b0;
    if (tset_d) begin
      sub_d  = 13'h0000;
      min_d  = tset_min;
      day_d  = tset_day;
      eval_d = 1'b1;
    end else if (tick_q) begin
      sub_d = sub_q + 13'h0001;
      if (sub_q == `RTSF_TICKS_PER_MIN - 13'h0001) begin
        sub_d  = 13'h0000;
        eval_d = 1'b1;
        min_d  = min_q + 11'h001;
        if (min_q == `RTSF_MIN_PER_DAY - 11'h001) begin
          min_d = 11'h000;
          day_d = (day_q == `RTSF_DAYS - 3'h1) ? 3'h0 : day_q + 3'h1;
        end
      end
    end

    tsw_next = out_q.tsw_q;
    if (lvl.tsw_rst) begin
      tsw_next = 1'b0;
    end else if (eval_q) begin
      // later cams overwrite earlier ones; off beats on within one cam
      for (int i = 0; i < 3; i++) begin
        if (day_hit(cam_q[i].day, day_q)) begin
          if (cam_q[i].on_min != `RTSF_TIME_UNSET && cam_q[i].on_min == min_q)
            tsw_next = 1'b1;
          if (cam_q[i].off_min != `RTSF_TIME_UNSET && cam_q[i].off_min == min_q)
            tsw_next = 1'b0;
        end
      end
    end
  end

  // the calendar is cleared only by presetn, never by mains restore
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_q  <= 13'h0000;
      min_q  <= 11'h000;
      day_q  <= 3'h0;
      eval_q <= 1'b0;
    end else begin
      sub_q  <= sub_d;
      min_q  <= min_d;
      day_q  <= day_d;
      eval_q <= eval_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_el_q   <= 16'h0000;
      off_el_q  <= 16'h0000;
      off_run_q <= 1'b0;
      out_q     <= 4'h0;
    end else begin
      on_el_q   <= on_el_d;
      off_el_q  <= off_el_d;
      off_run_q <= off_run_d;
      out_q     <= out_d;
    end
  end

  assign sf_out = out_q;

endmodule

// ---- rtsf_consts.svh ----
/*
  constants for the relay special-function block: register offsets,
  field positions, reset values and timing counts.
  assumes a 25 MHz pclk and APB byte addressing with 32-bit words.
*/
// Operation
// - reset input overrides every other block input
// - power restoration clears all elapsed times
// - timed intervals within one percent of setting; the code counts whole 10 ms ticks, so an interval can end up to one tick short
// - on-delay output rises after trigger held
// - early trigger fall clears on-delay count
// - on-delay output low while trigger low
// - off-delay output high at once
// - off-delay trigger fall starts the count
// - off-delay output drops when count equals delay
// - new falling edge restarts off-delay count
// - off-delay reset clears count, output low
// - pulse relay toggles on rising edges only
// - pulse relay low at power-on and reset
// - three cams drive one time-switch output
// - eleven day selections per cam
// - cam times stored as minutes of day
// - unset cam time never switches
// - on match sets, off match clears output
// - cam three beats two beats one
// - day and time counter survives mains loss
`ifndef RTSF_CONSTS_SVH
`define RTSF_CONSTS_SVH

`define RTSF_OFS_ON_DELAY   12'h000
`define RTSF_OFS_OFF_DELAY  12'h004
`define RTSF_OFS_CAM1       12'h008
`define RTSF_OFS_CAM2       12'h00C
`define RTSF_OFS_CAM3       12'h010
`define RTSF_OFS_TIME       12'h014
`define RTSF_OFS_STATUS     12'h018
`define RTSF_OFS_ON_ELAPSED 12'h01C
`define RTSF_OFS_OFF_ELAPSED 12'h020

`define RTSF_CAM_DAY_LSB    0
`define RTSF_CAM_ON_LSB     4
`define RTSF_CAM_OFF_LSB    15
`define RTSF_TIME_DAY_LSB   16

`define RTSF_DELAY_RST      16'h0000
`define RTSF_CAM_RST        26'h3FFFFF0
`define RTSF_TIME_UNSET     11'h7FF
`define RTSF_MIN_PER_DAY    11'h5A0
`define RTSF_DAYS           3'h7

`define RTSF_CLK_HZ         25000000
`define RTSF_TICK_US        10000
`define RTSF_TICK_CYC       ((`RTSF_CLK_HZ / 1000000) * `RTSF_TICK_US)
`define RTSF_TICKS_PER_MIN  13'h1770

`endif

// ---- rtsf_pkg.sv ----
/*
  types shared by the relay special-function block.
  assumes rtsf_consts.svh for all numeric constants.
*/
package rtsf_pkg;

  typedef struct packed {
    logic on_trg;
    logic on_rst;
    logic off_trg;
    logic off_rst;
    logic pls_trg;
    logic pls_rst;
    logic tsw_rst;
    logic pwr_ok;
  } rtsf_in_t;

  typedef struct packed {
    logic on_q;
    logic off_q;
    logic pls_q;
    logic tsw_q;
  } rtsf_out_t;

  typedef enum logic [3:0] {
    RTSF_SU = 4'h0, RTSF_MO = 4'h1, RTSF_TU = 4'h2, RTSF_WE = 4'h3,
    RTSF_TH = 4'h4, RTSF_FR = 4'h5, RTSF_SA = 4'h6, RTSF_MO_FR = 4'h7,
    RTSF_MO_SA = 4'h8, RTSF_MO_SU = 4'h9, RTSF_SA_SU = 4'hA
  } rtsf_day_sel_t;

  typedef struct packed {
    logic [10:0]   off_min;
    logic [10:0]   on_min;
    rtsf_day_sel_t day;
  } rtsf_cam_t;

endpackage

// ---- rtsf_properties.sv ----
/*
  port checker for rtsf_top, bound at the foot of this file.
  assumes five pclk edges from a block pin to the output it moves.
*/
`timescale 1ns/10ps

module rtsf_properties
  import rtsf_pkg::*;
(
  input wire logic      pclk,
  input wire logic      presetn,
  input wire logic      psel,
  input wire logic      penable,
  input wire logic      pready,
  input wire logic      pslverr,
  input wire rtsf_in_t  sf_in,
  input wire rtsf_out_t sf_out
);
  // seven held samples cover the pin synchroniser and the output flop
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_apb_one_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_err_in_access: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside an access");
  a_on_rst_wins: assert property (sf_in.on_rst [*7] |-> !sf_out.on_q)
    else $error("on_q high while held in reset");
  a_on_trg_low: assert property (!sf_in.on_trg [*7] |-> !sf_out.on_q)
    else $error("on_q high with trigger low");
  a_on_needs_hold: assert property ($rose(sf_out.on_q) |-> $past(sf_in.on_trg, 4))
    else $error("on_q rose without a held trigger");
  a_off_at_once: assert property (
    (sf_in.off_trg && !sf_in.off_rst && sf_in.pwr_ok) [*7] |-> sf_out.off_q)
    else $error("off_q low with trigger high");
  a_off_rst_low: assert property (sf_in.off_rst [*7] |-> !sf_out.off_q)
    else $error("off_q high while held in reset");
  a_pls_rst_low: assert property (sf_in.pls_rst [*7] |-> !sf_out.pls_q)
    else $error("pls_q high while held in reset");
  a_pls_on_rise: assert property ($rose(sf_out.pls_q) |-> $past(sf_in.pls_trg, 3))
    else $error("pls_q rose without a trigger rise");
  a_tsw_rst_low: assert property (sf_in.tsw_rst [*7] |-> !sf_out.tsw_q)
    else $error("tsw_q high while held in reset");

  c_on_fired: cover property ($rose(sf_out.on_q));
  c_off_fell: cover property ($fell(sf_out.off_q));
  c_tsw_set: cover property ($rose(sf_out.tsw_q));
endmodule

bind rtsf_top rtsf_properties u_props (.pclk, .presetn, .psel, .penable, .pready,
  .pslverr, .sf_in, .sf_out);

// ---- rtsf_top_tb.sv ----
/*
  bench for rtsf_top: apb registers, delay timers, pulse relay, time switch.
  assumes TICK_CYC of 4, so one delay tick is 4 pclk cycles.
*/
`timescale 1ns/10ps
`include "rtsf_consts.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("Error %s exp %0h got %0h", n, e, g); end end

module rtsf_top_tb
  import rtsf_pkg::*;
();
  localparam int ONT = 7, ONR = 6, OFT = 5, OFR = 4, PT = 3, PR = 2, TR = 1, PW = 0;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        pready, pslverr, ex;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pe = 4'h0;
  rtsf_in_t    si = 8'h01;
  rtsf_out_t   so;
  int          err_total = 0, total_checks = 0, t;

  rtsf_top #(.TICK_CYC(4)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sf_in(si), .sf_out(so));

  always #20 pclk = ~pclk;

  task automatic w(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // spare edge after release so the next call never drives psel twice at one edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    ex = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK("prdata", e, rd)
  endtask

  task automatic stp(input int b, input logic v, input int n, input logic [3:0] m, e);
    si[b] <= v;
    w(n);
    `CHK("sf_out", e, so & m)
  endtask

  task automatic tw(input int d, input int m, input logic e);
    apb(1'b1, `RTSF_OFS_TIME, 32'(d * 65536 + m));
    w(3);
    `CHK("tsw_q", e, so.tsw_q)
  endtask

  function automatic logic [31:0] cw(input int d, input int on, input int of);
    return 32'(of * 32768 + on * 16 + d);
  endfunction

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // the run needs under 2000 cycles
  initial begin
    #400000;
    err_total++;
    end_of_test();
  end

  initial begin
    w(10);
    presetn <= 1'b1;
    w(1);
    rdc(`RTSF_OFS_ON_DELAY, 32'h0);
    rdc(`RTSF_OFS_CAM2, `RTSF_CAM_RST);
    apb(1'b0, 12'h024, 32'h0);
    `CHK("pslverr", 1'b1, ex)
    $display("regs done");
    apb(1'b1, `RTSF_OFS_ON_DELAY, 32'h5);
    stp(ONT, 1'b1, 12, 4'h8, 4'h0);
    stp(ONT, 1'b0, 6, 4'h8, 4'h0);
    stp(ONT, 1'b1, 15, 4'h8, 4'h0);
    stp(ONT, 1'b1, 25, 4'h8, 4'h8);
    stp(ONR, 1'b1, 8, 4'h8, 4'h0);
    stp(ONT, 1'b0, 1, 4'h8, 4'h0);
    stp(ONR, 1'b0, 30, 4'h8, 4'h0);
    $display("on delay done");
    apb(1'b1, `RTSF_OFS_OFF_DELAY, 32'h5);
    stp(OFT, 1'b1, 7, 4'h4, 4'h4);
    stp(OFT, 1'b0, 12, 4'h4, 4'h4);
    stp(OFT, 1'b1, 7, 4'h4, 4'h4);
    stp(OFT, 1'b0, 15, 4'h4, 4'h4);
    stp(OFT, 1'b0, 20, 4'h4, 4'h0);
    stp(OFT, 1'b1, 7, 4'h4, 4'h4);
    stp(OFT, 1'b0, 6, 4'h4, 4'h4);
    stp(OFR, 1'b1, 8, 4'h4, 4'h0);
    stp(OFR, 1'b0, 30, 4'h4, 4'h0);
    $display("off delay done");
    for (int i = 0; i < 3; i++) begin
      pe = pe ^ 4'h2;
      stp(PT, 1'b1, 8, 4'h2, pe);
      stp(PT, 1'b0, 8, 4'h2, pe);
    end
    rdc(`RTSF_OFS_STATUS, 32'h2);
    stp(PR, 1'b1, 8, 4'h2, 4'h0);
    stp(PT, 1'b1, 8, 4'h2, 4'h0);
    stp(PR, 1'b0, 8, 4'h2, 4'h0);
    stp(PT, 1'b0, 8, 4'h2, 4'h0);
    stp(PT, 1'b1, 8, 4'h2, 4'h2);
    si[PW] <= 1'b0;
    w(8);
    stp(PW, 1'b1, 8, 4'h2, 4'h0);
    $display("pulse done");
    for (int d = 0; d < 11; d++) begin
      t = d < 7 ? d : (d == 10 ? 6 : 1);
      apb(1'b1, `RTSF_OFS_CAM1, cw(d, 100, 101));
      tw(d == 10 ? 1 : (d < 7 ? (d + 1) % 7 : 0), 100, d == 9);
      tw(t, 100, 1'b1);
      tw(t, 101, 1'b0);
    end
    apb(1'b1, `RTSF_OFS_CAM1, cw(9, 200, 2047));
    apb(1'b1, `RTSF_OFS_CAM2, cw(9, 2047, 200));
    tw(3, 200, 1'b0);
    apb(1'b1, `RTSF_OFS_CAM3, cw(3, 200, 2047));
    tw(3, 200, 1'b1);
    tw(4, 200, 1'b0);
    tw(3, 200, 1'b1);
    stp(TR, 1'b1, 8, 4'h1, 4'h0);
    apb(1'b1, `RTSF_OFS_TIME, 32'h5A0);
    rdc(`RTSF_OFS_TIME, 32'h000300C8);
    $display("time switch done");
    end_of_test();
  end
endmodule
